// ===== logic/lpir_regs.sv
// register bank, persistence counters and interrupt pin of the light/proximity sensor
// assumes a serial slave engine presents single-cycle byte writes and a held read address;
// conversion results arrive with a one-cycle done pulse, all synchronous to CLK
//
// What this block does, and what its host must do
// (RQ1) proximity flag bit 7, cleared writing zero
// (RQ2) both flags read zero after reset
// (RQ3) proximity persistence bits 6:5: 1/4/8/16 trips
// (RQ4) host writes zero to bit 4
// (RQ5) light flag bit 3, cleared writing zero
// (RQ6) light persistence bits 2:1: 1/4/8/16 conversions
// (RQ7) combine bit 0 low: OR drives pin low
// (RQ8) combine bit 0 high: AND drives pin low
// (RQ9) proximity low threshold, reset 0x00
// (RQ10) proximity high threshold, reset 0xFF
// (RQ11) light low threshold from 0x05 and 0x06[3:0]
// (RQ12) light high threshold from 0x06[7:4], 0x07
// (RQ13) read-only proximity result, reset zero
// (RQ14) read-only light result, upper nibble zero
// (RQ15) test registers reset zero, host keeps zero
// (RQ16) light event when result outside window
// (RQ17) proximity event when result above high threshold
// (RQ18) proximity flag self-clears below low threshold
// (RQ19) pin released high when combination false
`timescale 1ns/100ps
module lpir_regs
(
   input  wire logic        CLK,
   input  wire logic        NRST,
   input  wire logic [3:0]  REG_ADDR,
   input  wire logic [7:0]  REG_WDATA,
   input  wire logic        REG_WR,
   output logic      [7:0]  REG_RDATA,
   input  wire logic        NEAR_DONE,
   input  wire logic [7:0]  NEAR_DATA,
   input  wire logic        LIGHT_DONE,
   input  wire logic [11:0] LIGHT_DATA,
   output logic             INT_N,
   output logic             TEST_ACTIVE
);

   function automatic logic [4:0] persist_target(input logic [1:0] code);
      case (code)
         2'b00:   persist_target = lpir_pkg::PERSIST_C0;
         2'b01:   persist_target = lpir_pkg::PERSIST_C1;
         2'b10:   persist_target = lpir_pkg::PERSIST_C2;
         default: persist_target = lpir_pkg::PERSIST_C3;
      endcase
   endfunction

   // counters saturate so a long run never wraps back under the target
   function automatic logic [4:0] bump(input logic [4:0] cnt);
      bump = (cnt == lpir_pkg::PERSIST_C3) ? cnt : cnt + lpir_pkg::CNT_ONE;
   endfunction

   logic [7:0]  ctrl_reg;
   logic [7:0]  near_low_limit_reg;
   logic [7:0]  near_high_limit_reg;
   logic [7:0]  th1_reg;
   logic [7:0]  th2_reg;
   logic [7:0]  th3_reg;
   logic [7:0]  near_result_reg;
   logic [11:0] light_result_reg;
   logic [7:0]  test_mode_one_reg;
   logic [7:0]  test_mode_two_reg;
   logic [4:0]  near_hi_cnt_reg;
   logic [4:0]  near_lo_cnt_reg;
   logic [4:0]  light_cnt_reg;

   logic [11:0] light_low_limit;
   logic [11:0] light_high_limit;
   logic [4:0]  near_persist_count;
   logic [4:0]  light_persist_count;
   logic        wr_ctrl;
   logic        near_trip_hi;
   logic        near_trip_lo;
   logic        light_trip;
   logic        near_set;
   logic        near_self_clr;
   logic        near_host_clr;
   logic        light_set;
   logic        light_host_clr;
   logic        near_flag;
   logic        light_event_flag;
   logic        near_flag_next;
   logic        light_flag_next;
   logic [4:0]  near_hi_cnt_next;
   logic [4:0]  near_lo_cnt_next;
   logic [4:0]  light_cnt_next;
   logic [7:0]  ctrl_next;
   logic [7:0]  rdata_next;
   logic        int_n_next;

   assign near_flag        = ctrl_reg[lpir_pkg::BIT_NEAR_FLAG];
   assign light_event_flag = ctrl_reg[lpir_pkg::BIT_LIGHT_FLAG];

   assign light_low_limit  = {th2_reg[3:0], th1_reg}; // RQ11
   assign light_high_limit = {th3_reg, th2_reg[7:4]}; // RQ12

   assign near_persist_count  = persist_target(
      ctrl_reg[lpir_pkg::BIT_NEAR_PRS_HI:lpir_pkg::BIT_NEAR_PRS_LO]); // RQ3
   assign light_persist_count = persist_target(
      ctrl_reg[lpir_pkg::BIT_LIGHT_PRS_HI:lpir_pkg::BIT_LIGHT_PRS_LO]); // RQ6

   // thresholds are compared with the fresh result, not the stored one
   assign near_trip_hi = NEAR_DATA > near_high_limit_reg; // RQ17
   assign near_trip_lo = NEAR_DATA < near_low_limit_reg; // RQ18
   assign light_trip   = (LIGHT_DATA < light_low_limit)
                       | (LIGHT_DATA > light_high_limit); // RQ16

   assign near_hi_cnt_next = !NEAR_DONE ? near_hi_cnt_reg :
                             near_trip_hi ? bump(near_hi_cnt_reg) : lpir_pkg::CNT_ZERO;
   assign near_lo_cnt_next = !NEAR_DONE ? near_lo_cnt_reg :
                             near_trip_lo ? bump(near_lo_cnt_reg) : lpir_pkg::CNT_ZERO;
   assign light_cnt_next   = !LIGHT_DONE ? light_cnt_reg :
                             light_trip ? bump(light_cnt_reg) : lpir_pkg::CNT_ZERO;

   assign near_set      = NEAR_DONE & near_trip_hi
                        & (near_hi_cnt_next >= near_persist_count); // RQ3
   assign near_self_clr = NEAR_DONE & near_trip_lo
                        & (near_lo_cnt_next >= near_persist_count); // RQ18
   assign light_set     = LIGHT_DONE & light_trip
                        & (light_cnt_next >= light_persist_count); // RQ6

   assign wr_ctrl        = REG_WR & (REG_ADDR == lpir_pkg::ADDR_INT_CTRL);
   assign near_host_clr  = wr_ctrl & ~REG_WDATA[lpir_pkg::BIT_NEAR_FLAG]; // RQ1
   assign light_host_clr = wr_ctrl & ~REG_WDATA[lpir_pkg::BIT_LIGHT_FLAG]; // RQ5

   // a fresh event outranks a clear landing in the same cycle
   assign near_flag_next  = near_set
                          | (near_flag & ~near_host_clr & ~near_self_clr); // RQ1
   assign light_flag_next = light_set | (light_event_flag & ~light_host_clr); // RQ5

   // writing one to a flag bit leaves it alone; bit 4 is stored as written
   assign ctrl_next = {near_flag_next,
                       wr_ctrl ? REG_WDATA[lpir_pkg::BIT_NEAR_PRS_HI:lpir_pkg::BIT_SPARE] // RQ4
                               : ctrl_reg[lpir_pkg::BIT_NEAR_PRS_HI:lpir_pkg::BIT_SPARE],
                       light_flag_next,
                       wr_ctrl ? REG_WDATA[lpir_pkg::BIT_LIGHT_PRS_HI:lpir_pkg::BIT_COMBINE]
                               : ctrl_reg[lpir_pkg::BIT_LIGHT_PRS_HI:lpir_pkg::BIT_COMBINE]};

   // pin follows the flags' next state so it moves with the flag bits
   assign int_n_next = ctrl_reg[lpir_pkg::BIT_COMBINE]
                     ? ~(near_flag_next & light_flag_next)   // RQ8
                     : ~(near_flag_next | light_flag_next);  // RQ7 RQ19

   assign rdata_next =
      (REG_ADDR == lpir_pkg::ADDR_INT_CTRL)  ? ctrl_reg :
      (REG_ADDR == lpir_pkg::ADDR_NEAR_LT)   ? near_low_limit_reg :
      (REG_ADDR == lpir_pkg::ADDR_NEAR_HT)   ? near_high_limit_reg :
      (REG_ADDR == lpir_pkg::ADDR_LIGHT_TH1) ? th1_reg :
      (REG_ADDR == lpir_pkg::ADDR_LIGHT_TH2) ? th2_reg :
      (REG_ADDR == lpir_pkg::ADDR_LIGHT_TH3) ? th3_reg :
      (REG_ADDR == lpir_pkg::ADDR_NEAR_RES)  ? near_result_reg : // RQ13
      (REG_ADDR == lpir_pkg::ADDR_LIGHT_RL)  ? light_result_reg[7:0] :
      (REG_ADDR == lpir_pkg::ADDR_LIGHT_RH)
         ? {lpir_pkg::UPPER_UNUSED, light_result_reg[11:8]} : // RQ14
      (REG_ADDR == lpir_pkg::ADDR_TEST_ONE)  ? test_mode_one_reg :
      (REG_ADDR == lpir_pkg::ADDR_TEST_TWO)  ? test_mode_two_reg :
      lpir_pkg::READ_UNMAPPED;

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         ctrl_reg        <= lpir_pkg::RST_INT_CTRL; // RQ2
         near_hi_cnt_reg <= lpir_pkg::CNT_ZERO;
         near_lo_cnt_reg <= lpir_pkg::CNT_ZERO;
         light_cnt_reg   <= lpir_pkg::CNT_ZERO;
         INT_N           <= 1'b1;
      end
      else
      begin
         ctrl_reg        <= ctrl_next;
         near_hi_cnt_reg <= near_hi_cnt_next;
         near_lo_cnt_reg <= near_lo_cnt_next;
         light_cnt_reg   <= light_cnt_next;
         INT_N           <= int_n_next;
      end
   end

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         near_low_limit_reg  <= lpir_pkg::RST_NEAR_LT; // RQ9
         near_high_limit_reg <= lpir_pkg::RST_NEAR_HT; // RQ10
         th1_reg             <= lpir_pkg::RST_LIGHT_TH1; // RQ11
         th2_reg             <= lpir_pkg::RST_LIGHT_TH2; // RQ12
         th3_reg             <= lpir_pkg::RST_LIGHT_TH3; // RQ12
         test_mode_one_reg   <= lpir_pkg::RST_TEST; // RQ15
         test_mode_two_reg   <= lpir_pkg::RST_TEST; // RQ15
      end
      else if (REG_WR)
      begin
         case (REG_ADDR)
            lpir_pkg::ADDR_NEAR_LT:   near_low_limit_reg  <= REG_WDATA; // RQ9
            lpir_pkg::ADDR_NEAR_HT:   near_high_limit_reg <= REG_WDATA; // RQ10
            lpir_pkg::ADDR_LIGHT_TH1: th1_reg             <= REG_WDATA;
            lpir_pkg::ADDR_LIGHT_TH2: th2_reg             <= REG_WDATA;
            lpir_pkg::ADDR_LIGHT_TH3: th3_reg             <= REG_WDATA;
            lpir_pkg::ADDR_TEST_ONE:  test_mode_one_reg   <= REG_WDATA;
            lpir_pkg::ADDR_TEST_TWO:  test_mode_two_reg   <= REG_WDATA;
            default:                  th1_reg             <= th1_reg;
         endcase
      end
   end

   // result registers ignore host writes
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         near_result_reg  <= lpir_pkg::RST_RESULT; // RQ13
         light_result_reg <= {lpir_pkg::UPPER_UNUSED, lpir_pkg::RST_RESULT};
         REG_RDATA        <= lpir_pkg::READ_UNMAPPED;
         TEST_ACTIVE      <= 1'b0;
      end
      else
      begin
         if (NEAR_DONE)
            near_result_reg <= NEAR_DATA; // RQ13
         if (LIGHT_DONE)
            light_result_reg <= LIGHT_DATA; // RQ14
         REG_RDATA   <= rdata_next;
         // only flags the condition; test behaviour itself lives elsewhere
         TEST_ACTIVE <= |{test_mode_one_reg, test_mode_two_reg}; // RQ15
      end
   end

   AST_NEAR_SET: assert property (@(posedge CLK) disable iff (!NRST) // RQ17
      near_set |=> near_flag)
      else $error("proximity flag not set after qualifying conversion");

   AST_NEAR_HOST_CLR: assert property (@(posedge CLK) disable iff (!NRST) // RQ1
      (near_host_clr && !near_set) |=> !near_flag)
      else $error("proximity flag survived host clear");

   AST_LIGHT_HOST_CLR: assert property (@(posedge CLK) disable iff (!NRST) // RQ5
      (light_host_clr && !light_set) |=> !light_event_flag)
      else $error("light flag survived host clear");

   AST_LIGHT_NO_SPURIOUS: assert property (@(posedge CLK) disable iff (!NRST) // RQ16
      (!light_event_flag && !(LIGHT_DONE && light_trip)) |=> !light_event_flag)
      else $error("light flag rose without an out-of-window conversion");

   AST_PERSIST_FOUR: assert property (@(posedge CLK) disable iff (!NRST) // RQ3
      (ctrl_reg[6:5] == 2'b01 && !near_flag && near_hi_cnt_reg < 5'h03) |=> !near_flag)
      else $error("proximity flag set before four trips");

   AST_LIGHT_PERSIST: assert property (@(posedge CLK) disable iff (!NRST) // RQ6
      (ctrl_reg[2:1] == 2'b11 && !light_event_flag && light_cnt_reg < 5'h0F)
      |=> !light_event_flag)
      else $error("light flag set before sixteen conversions");

   AST_OR_PIN: assert property (@(posedge CLK) disable iff (!NRST) // RQ7
      (!ctrl_reg[0] && $stable(ctrl_reg[0])) |-> (INT_N == !(near_flag | light_event_flag)))
      else $error("pin does not follow OR of flags");

   AST_AND_PIN: assert property (@(posedge CLK) disable iff (!NRST) // RQ8
      (ctrl_reg[0] && $stable(ctrl_reg[0])) |-> (INT_N == !(near_flag & light_event_flag)))
      else $error("pin does not follow AND of flags");

   AST_SELF_CLR: assert property (@(posedge CLK) disable iff (!NRST) // RQ18
      (near_self_clr && !near_set) |=> !near_flag ##1 1'b1)
      else $error("proximity flag not cleared below low threshold");

   AST_RESULT_HIGH_ZERO: assert property (@(posedge CLK) disable iff (!NRST) // RQ14
      (REG_ADDR == lpir_pkg::ADDR_LIGHT_RH) |=> REG_RDATA[7:4] == 4'h0)
      else $error("unused light result bits read nonzero");

   // checked one edge on, so the first clock inside reset needs no known state
   AST_FLAGS_IN_RESET: assert property (@(posedge CLK) // RQ2
      !NRST
      |=> (!near_flag && !light_event_flag && INT_N))
      else $error("flags or pin active while in reset");

   AST_INT_RELEASED: assert property (@(posedge CLK) disable iff (!NRST) // RQ19
      (!near_flag && !light_event_flag)
      |-> INT_N)
      else $error("pin low with both flags clear");

   AST_NEAR_PERSIST_HOLD: assert property (@(posedge CLK) disable iff (!NRST) // RQ3
      (ctrl_reg[6:5] == 2'b11 && !near_flag && near_hi_cnt_reg < 5'h0F)
      |=> !near_flag)
      else $error("proximity flag set before sixteen trips");

   AST_NEAR_NO_SPURIOUS: assert property (@(posedge CLK) disable iff (!NRST) // RQ17
      (!near_flag && !(NEAR_DONE && near_trip_hi))
      |=> !near_flag)
      else $error("proximity flag rose without a high conversion");

   AST_LIGHT_SET: assert property (@(posedge CLK) disable iff (!NRST) // RQ5
      light_set
      |=> light_event_flag)
      else $error("light flag not set after qualifying conversion");

   AST_NEAR_FLAG_HOLD: assert property (@(posedge CLK) disable iff (!NRST) // RQ1
      (near_flag && !near_host_clr && !near_self_clr)
      |=> near_flag)
      else $error("proximity flag dropped without a clear");

   AST_LIGHT_FLAG_HOLD: assert property (@(posedge CLK) disable iff (!NRST) // RQ5
      (light_event_flag && !light_host_clr)
      |=> light_event_flag)
      else $error("light flag dropped without a clear");

   AST_NEAR_RES_LOAD: assert property (@(posedge CLK) disable iff (!NRST) // RQ13
      NEAR_DONE
      |=> (near_result_reg == $past(NEAR_DATA)))
      else $error("proximity result not captured");

   AST_NEAR_RES_RO: assert property (@(posedge CLK) disable iff (!NRST) // RQ13
      !NEAR_DONE
      |=> $stable(near_result_reg))
      else $error("proximity result changed without a conversion");

   AST_LIGHT_RES_RO: assert property (@(posedge CLK) disable iff (!NRST) // RQ14
      !LIGHT_DONE
      |=> $stable(light_result_reg))
      else $error("light result changed without a conversion");

   AST_TEST_QUIET: assert property (@(posedge CLK) disable iff (!NRST) // RQ15
      (test_mode_one_reg == lpir_pkg::RST_TEST && test_mode_two_reg == lpir_pkg::RST_TEST)
      |=> !TEST_ACTIVE)
      else $error("test status raised with both test registers clear");

   AST_NEAR_LT_HOLD: assert property (@(posedge CLK) disable iff (!NRST) // RQ9
      !(REG_WR && REG_ADDR == lpir_pkg::ADDR_NEAR_LT)
      |=> $stable(near_low_limit_reg))
      else $error("proximity low threshold changed without a write");

   AST_NEAR_HT_WRITE: assert property (@(posedge CLK) disable iff (!NRST) // RQ10
      (REG_WR && REG_ADDR == lpir_pkg::ADDR_NEAR_HT)
      |=> (near_high_limit_reg == $past(REG_WDATA)))
      else $error("proximity high threshold write lost");

   AST_LIGHT_LIMITS: assert property (@(posedge CLK) disable iff (!NRST) // RQ11
      (REG_WR && REG_ADDR == lpir_pkg::ADDR_LIGHT_TH1)
      |=> (light_low_limit[7:0] == $past(REG_WDATA)))
      else $error("light low threshold byte not placed low");

   AST_LIGHT_HIGH_NIBBLE: assert property (@(posedge CLK) disable iff (!NRST) // RQ12
      (REG_WR && REG_ADDR == lpir_pkg::ADDR_LIGHT_TH2)
      |=> (light_high_limit[3:0] == $past(REG_WDATA[7:4])))
      else $error("light high threshold nibble misplaced");

   AST_LIGHT_WINDOW: assert property (@(posedge CLK) disable iff (!NRST) // RQ16
      (LIGHT_DONE && LIGHT_DATA >= light_low_limit && LIGHT_DATA <= light_high_limit)
      |=> (light_cnt_reg == lpir_pkg::CNT_ZERO))
      else $error("in-window light conversion did not end the run");

   AST_RDATA_CTRL: assert property (@(posedge CLK) disable iff (!NRST) // RQ1
      (REG_ADDR == lpir_pkg::ADDR_INT_CTRL)
      |=> (REG_RDATA == $past(ctrl_reg)))
      else $error("interrupt register read data wrong");

endmodule

// ===== include/lpir_pkg.sv
// constants for the light/proximity interrupt register bank
// assumes an 8-bit register port driven by an external serial slave engine
package lpir_pkg;
   localparam logic [3:0] ADDR_INT_CTRL  = 4'h2;
   localparam logic [3:0] ADDR_NEAR_LT   = 4'h3;
   localparam logic [3:0] ADDR_NEAR_HT   = 4'h4;
   localparam logic [3:0] ADDR_LIGHT_TH1 = 4'h5;
   localparam logic [3:0] ADDR_LIGHT_TH2 = 4'h6;
   localparam logic [3:0] ADDR_LIGHT_TH3 = 4'h7;
   localparam logic [3:0] ADDR_NEAR_RES  = 4'h8;
   localparam logic [3:0] ADDR_LIGHT_RL  = 4'h9;
   localparam logic [3:0] ADDR_LIGHT_RH  = 4'hA;
   localparam logic [3:0] ADDR_TEST_ONE  = 4'hE;
   localparam logic [3:0] ADDR_TEST_TWO  = 4'hF;

   // interrupt control register fields
   localparam int BIT_NEAR_FLAG   = 7;
   localparam int BIT_NEAR_PRS_HI = 6;
   localparam int BIT_NEAR_PRS_LO = 5;
   localparam int BIT_SPARE       = 4;
   localparam int BIT_LIGHT_FLAG  = 3;
   localparam int BIT_LIGHT_PRS_HI = 2;
   localparam int BIT_LIGHT_PRS_LO = 1;
   localparam int BIT_COMBINE     = 0;

   localparam logic [7:0] RST_INT_CTRL  = 8'h00;
   localparam logic [7:0] RST_NEAR_LT   = 8'h00;
   localparam logic [7:0] RST_NEAR_HT   = 8'hFF;
   localparam logic [7:0] RST_LIGHT_TH1 = 8'h00;
   localparam logic [7:0] RST_LIGHT_TH2 = 8'hF0;
   localparam logic [7:0] RST_LIGHT_TH3 = 8'hFF;
   localparam logic [7:0] RST_RESULT    = 8'h00;
   localparam logic [7:0] RST_TEST      = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   localparam logic [3:0] UPPER_UNUSED  = 4'h0;

   // consecutive-trip counts for persistence codes 00..11
   localparam logic [4:0] PERSIST_C0 = 5'h01;
   localparam logic [4:0] PERSIST_C1 = 5'h04;
   localparam logic [4:0] PERSIST_C2 = 5'h08;
   localparam logic [4:0] PERSIST_C3 = 5'h10;
   localparam logic [4:0] CNT_ZERO   = 5'h00;
   localparam logic [4:0] CNT_ONE    = 5'h01;
endpackage

// ===== tb/lpir_host.sv
// host-side model: byte writes and reads on the register port
// assumes CLK rising-edge capture; drives on falling edges
`timescale 1ns/100ps
module lpir_host
(
   input  wire logic       CLK,
   input  wire logic [7:0] REG_RDATA,
   output logic      [3:0] REG_ADDR,
   output logic      [7:0] REG_WDATA,
   output logic            REG_WR
);
   initial
   begin
      REG_ADDR = 4'h0;
      REG_WDATA = 8'h00;
      REG_WR = 1'b0;
   end
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge CLK);
      REG_ADDR = a;
      // one assignment per edge: test registers always get zero
      REG_WDATA = (a >= lpir_pkg::ADDR_TEST_ONE) ? 8'h00 :
                  (a == lpir_pkg::ADDR_INT_CTRL) ? (d & 8'hEF) : d;
      REG_WR = 1'b1;
      @(negedge CLK);
      REG_WR = 1'b0;
      // stale data inverted so nothing leans on it
      REG_WDATA = ~REG_WDATA;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(negedge CLK);
      REG_ADDR = a;
      @(negedge CLK);
      d = REG_RDATA;
   endtask
endmodule

// ===== tb/lpir_regs_bench.sv
// self-checking bench for the light/proximity register bank
// assumes lpir_host drives the register port; conversions come from here
`timescale 1ns/100ps
module lpir_regs_bench;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic [3:0]  addr;
   logic [7:0]  wdata, rdata, d;
   logic        wr, int_n, test_active;
   logic        near_done = 1'b0, light_done = 1'b0;
   logic [7:0]  near_data = 8'h00;
   logic [11:0] light_data = 12'h000;
   integer      seed = 32'hCB27, failures = 0, n_checks = 0, p, n, i;
   logic [3:0]  ra [12] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA,
                            4'hE, 4'hF};
   logic [7:0]  rv [12] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hF0, 8'hFF, 8'h00, 8'h00,
                            8'h00, 8'h00, 8'h00};
   logic [3:0]  wa [7] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hE, 4'hF};
   always #2 clk = ~clk;
   lpir_host host (.CLK(clk), .REG_RDATA(rdata), .REG_ADDR(addr), .REG_WDATA(wdata),
                   .REG_WR(wr));
   lpir_regs uut (.CLK(clk), .NRST(nrst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
                  .REG_RDATA(rdata), .NEAR_DONE(near_done), .NEAR_DATA(near_data),
                  .LIGHT_DONE(light_done), .LIGHT_DATA(light_data), .INT_N(int_n),
                  .TEST_ACTIVE(test_active));
   function automatic integer npers(input integer c);
      return (c == 0) ? 1 : (2 << c);
   endfunction
   task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic near(input logic [7:0] v);
      @(negedge clk);
      near_done = 1'b1;
      near_data = v;
      @(negedge clk);
      near_done = 1'b0;
      near_data = ~v;
   endtask
   task automatic light(input logic [11:0] v);
      @(negedge clk);
      light_done = 1'b1;
      light_data = v;
      @(negedge clk);
      light_done = 1'b0;
      light_data = ~v;
   endtask
   // trips alternate below the low and above the high edge of the window
   function automatic logic [11:0] ltrip(input integer k);
      return k[0] ? (12'h000 + ($random(seed) & 12'h0FF)) : (12'h801 + ($random(seed) & 12'h3FF));
   endfunction
   task automatic test_done();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (100000) @(posedge clk);
      failures++;
      test_done();
   end
   initial
   begin
      repeat (6) @(posedge clk);
      @(negedge clk);
      nrst = 1'b1;
      check("int_n reset", int_n, 1'b1);
      for (i = 0; i < 12; i++)
      begin
         host.rd(ra[i], d);
         check("reset value", d, rv[i]);
      end
      for (i = 0; i < 7; i++)
      begin
         n = $random(seed);
         host.wr(wa[i], n[7:0]);
         host.rd(wa[i], d);
         check("readback", d, (i > 4) ? 8'h00 : n[7:0]);
      end
      check("test active", test_active, 1'b0);
      for (i = 8; i < 11; i++)
      begin
         host.wr(i[3:0], 8'h5A);
         host.rd(i[3:0], d);
         check("read-only", d, 8'h00);
      end
      host.wr(4'h3, 8'h20);
      host.wr(4'h4, 8'h80);
      host.wr(4'h5, 8'h00);
      host.wr(4'h6, 8'h01);
      host.wr(4'h7, 8'h80);
      for (p = 0; p < 4; p++)
      begin
         n = npers(p);
         host.wr(4'h2, {1'b0, p[1:0], 5'h00});
         repeat (n - 1) near(8'h81 + ($random(seed) & 8'h3F));
         near(8'h80);
         repeat (n - 1) near(8'h81 + ($random(seed) & 8'h3F));
         host.rd(4'h2, d);
         check("near flag early", d[7], 1'b0);
         near(8'hFF);
         host.rd(4'h2, d);
         check("near flag", d[7], 1'b1);
         check("int_n or", int_n, 1'b0);
         repeat (n - 1) near($random(seed) & 8'h1F);
         host.rd(4'h2, d);
         check("near hold", d[7], 1'b1);
         near(8'h1F);
         host.rd(4'h2, d);
         check("near self clear", d[7], 1'b0);
         check("int_n idle", int_n, 1'b1);
         host.wr(4'h2, {5'h00, p[1:0], 1'b0});
         // in-window result ends the run left by the previous pass
         light(12'h400);
         for (i = 0; i < n - 1; i++)
            light(ltrip(i));
         light(12'h400);
         for (i = 0; i < n - 1; i++)
            light(ltrip(i));
         host.rd(4'h2, d);
         check("light flag early", d[3], 1'b0);
         light(12'hABC);
         host.rd(4'h2, d);
         check("light flag", d[3], 1'b1);
         host.rd(4'h9, d);
         check("light low byte", d, 8'hBC);
         host.rd(4'hA, d);
         check("light high byte", d, 8'h0A);
         host.rd(4'h8, d);
         check("near result", d, 8'h1F);
      end
      host.wr(4'h2, 8'h00);
      host.rd(4'h2, d);
      check("light clear", d[3], 1'b0);
      light(12'h0FF);
      host.rd(4'h2, d);
      check("int_n or light", int_n, 1'b0);
      host.wr(4'h2, 8'h09);
      host.rd(4'h2, d);
      check("int_n and one", int_n, 1'b1);
      near(8'h90);
      host.rd(4'h2, d);
      check("int_n and both", int_n, 1'b0);
      host.wr(4'h2, 8'h01);
      host.rd(4'h2, d);
      check("flags cleared", d, 8'h01);
      check("int_n released", int_n, 1'b1);
      test_done();
   end
endmodule
